// >>> shared/nand_host_pkg.sv
// Constants and types shared by the flash bus controller
package nand_host_pkg;

   // Timing in nanoseconds, sync depth and derived counts in cycles, at a 25 ns clock
   localparam int CLK_NS    = 25;
   localparam int SETUP_NS  = 25;
   localparam int STROBE_NS = 50;
   localparam int HOLD_NS   = 25;
   localparam int WB_NS     = 100;
   localparam int LOAD_NS   = 27000;
   localparam int SYNC_CYC  = 3;
   localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_CYC     = (WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_LOW_CYC = STROBE_CYC + SYNC_CYC;
   localparam int LOAD_CYC   = LOAD_NS / CLK_NS;

   // Register byte offsets
   localparam logic [4:0] REG_CTRL   = 5'h00;
   localparam logic [4:0] REG_ADDR   = 5'h04;
   localparam logic [4:0] REG_DATA   = 5'h08;
   localparam logic [4:0] REG_STATUS = 5'h0C;

   // Control fields
   localparam int CTRL_START  = 0;
   localparam int CTRL_OP_LSB = 1;
   localparam int CTRL_BUS16  = 4;
   localparam int CTRL_SKIP   = 5;
   localparam int CTRL_GUARD  = 6;
   localparam int CTRL_WAIT   = 7;

   // Status fields
   localparam int ST_ACTIVE  = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_READY   = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_TIMEOUT = 4;

   // Command codes
   localparam logic [7:0] CMD_READ       = 8'h00;
   localparam logic [7:0] CMD_READ_CONF  = 8'h30;
   localparam logic [7:0] CMD_COPY_READ  = 8'h35;
   localparam logic [7:0] CMD_CACHE_RD   = 8'h31;
   localparam logic [7:0] CMD_CACHE_EXIT = 8'h34;
   localparam logic [7:0] CMD_PROG       = 8'h80;
   localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
   localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
   localparam logic [7:0] CMD_COPY_PROG  = 8'h85;
   localparam logic [7:0] CMD_ERASE      = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONF = 8'hD0;
   localparam logic [7:0] CMD_STATUS     = 8'h70;
   localparam logic [7:0] CMD_ID         = 8'h90;
   localparam logic [7:0] CMD_RESET      = 8'hFF;
   localparam logic [7:0] CMD_RAND_OUT   = 8'h05;
   localparam logic [7:0] CMD_RAND_CONF  = 8'hE0;

   typedef enum logic [2:0] {
      OP_PAGE_READ  = 3'h0,
      OP_RAND_OUT   = 3'h1,
      OP_STATUS     = 3'h2,
      OP_READ_WORD  = 3'h3,
      OP_RESET      = 3'h4,
      OP_WRITE_WORD = 3'h5,
      OP_CMD        = 3'h6,
      OP_ADDR       = 3'h7
   } op_t;

   typedef enum logic [2:0] {
      PH_IDLE       = 3'h0,
      PH_SETUP      = 3'h1,
      PH_LOW        = 3'h2,
      PH_HIGH       = 3'h3,
      PH_WAIT_BUSY  = 3'h4,
      PH_WAIT_READY = 3'h5
   } phase_t;

   typedef enum logic [1:0] {
      K_CMD  = 2'h0,
      K_ADDR = 2'h1,
      K_DIN  = 2'h2,
      K_DOUT = 2'h3
   } kind_t;

   typedef struct packed {
      kind_t       kind;
      logic [15:0] data;
   } step_t;

   typedef struct packed {
      logic        cle;
      logic        ale;
      logic        ce_n;
      logic        we_n;
      logic        re_n;
      logic        wp_n;
      logic [15:0] io_out;
      logic        io_oe;
   } pin_out_t;

   localparam pin_out_t PINS_IDLE = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1,
      we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0, io_out: 16'h0000, io_oe: 1'b0};

endpackage

// >>> rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clock,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_t;

   sync_t s_r;
   sync_t s_nxt;

   always_comb begin
      s_nxt    = s_r;
      s_nxt.s1 = din;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      // A bit follows only once stages two and three agree
      s_nxt.q  = (s_r.s2 & ~(s_r.s2 ^ s_r.s3)) | (s_r.q & (s_r.s2 ^ s_r.s3));
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dout = s_r.q;
endmodule
`default_nettype wire

// >>> rtl/nand_host_ctrl.sv
// Host controller driving a parallel flash bus from a register port
// What this block does
// - Command bytes: select low, cle high, strobe rises
// - Command codes ride the low eight lines
// - Address bytes: select low, ale high, strobe rises
// - Full address takes four address cycles
// - Eight-bit bus address byte layout
// - Sixteen-bit bus address layout, upper lines low
// - Read, program, erase, status, ID command pairs
// - Copy-back and cache command pairs
// - Data words written on write strobe rise
// - Data words read by read strobe toggles
// - Guard must be high for program or erase commands and data words, not for address cycles
// - Page read: 00h, four addresses, 30h
// - Repeat read may omit leading 00h
// - Random output: 05h, column, E0h
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl #(
   parameter int LOAD_CYC = nand_host_pkg::LOAD_CYC
) (
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   input  wire logic [4:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_write,
   input  wire logic                    reg_read,
   output var  logic [31:0]             reg_rdata,
   output var  nand_host_pkg::pin_out_t pins,
   input  wire logic                    ready_busy_n,
   input  wire logic [15:0]             io_in
);
   typedef struct packed {
      nand_host_pkg::phase_t   ph;
      nand_host_pkg::op_t      op;
      logic [2:0]              idx;
      logic [10:0]             cnt;
      logic                    bus16;
      logic                    skip;
      logic                    guard;
      logic                    wait_rdy;
      logic [27:0]             addr;
      logic [15:0]             wword;
      logic [15:0]             rword;
      logic                    done;
      logic                    refused;
      logic                    timeout;
      nand_host_pkg::pin_out_t pins;
      logic [31:0]             rdata;
   } state_t;

   state_t      s_r;
   state_t      s_nxt;
   logic        rb_s;
   logic [15:0] io_s;
   logic [16:0] sync_q;

   // Ready line and data lines cross in through the synchroniser
   pin_sync #(.W(17), .INIT(17'h10000)) u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .din    ({ready_busy_n, io_in}),
      .dout   (sync_q)
   );
   assign rb_s = sync_q[16];
   assign io_s = sync_q[15:0];

   // Address byte n of four for either bus width
   function automatic logic [7:0] addr_byte(input logic [27:0] a,
                                            input logic [1:0]  n,
                                            input logic        b16);
      logic [7:0] r;
      r = 8'h00;
      if (b16) begin
         unique case (n)
            2'h0: r = a[7:0];
            2'h1: r = {5'h00, a[10:8]};
            2'h2: r = a[18:11];
            2'h3: r = a[26:19];
         endcase
      end else begin
         unique case (n)
            2'h0: r = a[7:0];
            2'h1: r = {4'h0, a[11:8]};
            2'h2: r = a[19:12];
            2'h3: r = a[27:20];
         endcase
      end
      return r;
   endfunction

   // Bus cycle idx of an operation
   function automatic nand_host_pkg::step_t step_of(
         input nand_host_pkg::op_t op, input logic [2:0] idx,
         input logic skp, input logic b16,
         input logic [27:0] a, input logic [15:0] w);
      nand_host_pkg::step_t s;
      logic [2:0]           i;
      s.kind = nand_host_pkg::K_CMD;
      s.data = 16'h0000;
      i = idx + {2'b00, skp & (op == nand_host_pkg::OP_PAGE_READ)};
      unique case (op)
         nand_host_pkg::OP_PAGE_READ: begin
            if (i == 3'd0) begin
               s.data = {8'h00, nand_host_pkg::CMD_READ};
            end else if (i <= 3'd4) begin
               s.kind = nand_host_pkg::K_ADDR;
               s.data = {8'h00, addr_byte(a, i[1:0] - 2'd1, b16)};
            end else begin
               s.data = {8'h00, nand_host_pkg::CMD_READ_CONF};
            end
         end
         nand_host_pkg::OP_RAND_OUT: begin
            if (i == 3'd0) begin
               s.data = {8'h00, nand_host_pkg::CMD_RAND_OUT};
            end else if (i <= 3'd2) begin
               s.kind = nand_host_pkg::K_ADDR;
               s.data = {8'h00, addr_byte(a, i[1:0] - 2'd1, b16)};
            end else begin
               s.data = {8'h00, nand_host_pkg::CMD_RAND_CONF};
            end
         end
         nand_host_pkg::OP_STATUS:
            s.data = {8'h00, nand_host_pkg::CMD_STATUS};
         nand_host_pkg::OP_READ_WORD:
            s.kind = nand_host_pkg::K_DOUT;
         nand_host_pkg::OP_RESET:
            s.data = {8'h00, nand_host_pkg::CMD_RESET};
         nand_host_pkg::OP_WRITE_WORD: begin
            s.kind = nand_host_pkg::K_DIN;
            s.data = b16 ? w : {8'h00, w[7:0]};
         end
         nand_host_pkg::OP_CMD:
            s.data = {8'h00, w[7:0]};
         nand_host_pkg::OP_ADDR: begin
            s.kind = nand_host_pkg::K_ADDR;
            s.data = {8'h00, w[7:0]};
         end
      endcase
      return s;
   endfunction

   function automatic logic [2:0] last_step(input nand_host_pkg::op_t op,
                                            input logic skp);
      logic [2:0] r;
      r = 3'd0;
      if (op == nand_host_pkg::OP_PAGE_READ) begin
         r = skp ? 3'd4 : 3'd5;
      end else if (op == nand_host_pkg::OP_RAND_OUT) begin
         r = 3'd3;
      end
      return r;
   endfunction

   function automatic logic modifies(input logic [7:0] c);
      return c == nand_host_pkg::CMD_PROG || c == nand_host_pkg::CMD_COPY_PROG
          || c == nand_host_pkg::CMD_ERASE
          || c == nand_host_pkg::CMD_PROG_CONF
          || c == nand_host_pkg::CMD_CACHE_PROG
          || c == nand_host_pkg::CMD_ERASE_CONF;
   endfunction

   nand_host_pkg::step_t st;
   nand_host_pkg::op_t   new_op;
   logic                 idle;
   logic                 allowed;
   logic                 guarded;
   logic                 waits;

   always_comb begin
      s_nxt  = s_r;
      st     = step_of(s_r.op, s_r.idx, s_r.skip, s_r.bus16, s_r.addr,
                       s_r.wword);
      new_op = nand_host_pkg::op_t'(reg_wdata[nand_host_pkg::CTRL_OP_LSB +: 3]);
      idle   = s_r.ph == nand_host_pkg::PH_IDLE;
      // Only reset and status may go out while the device is busy
      allowed = rb_s || new_op == nand_host_pkg::OP_RESET
             || new_op == nand_host_pkg::OP_STATUS
             || (new_op == nand_host_pkg::OP_CMD
                 && (s_r.wword[7:0] == nand_host_pkg::CMD_RESET
                     || s_r.wword[7:0] == nand_host_pkg::CMD_STATUS));
      guarded = reg_wdata[nand_host_pkg::CTRL_GUARD]
             || !(new_op == nand_host_pkg::OP_WRITE_WORD
                  || (new_op == nand_host_pkg::OP_CMD
                      && modifies(s_r.wword[7:0])));
      waits = s_r.op == nand_host_pkg::OP_PAGE_READ
           || s_r.op == nand_host_pkg::OP_RESET
           || (s_r.op == nand_host_pkg::OP_CMD && s_r.wait_rdy);
      s_nxt.pins.wp_n = s_r.guard;
      s_nxt.rdata = 32'h0000_0000;

      if (reg_read) begin
         unique case (reg_addr)
            nand_host_pkg::REG_CTRL:
               s_nxt.rdata = {24'h000000, s_r.wait_rdy, s_r.guard, s_r.skip,
                              s_r.bus16, s_r.op, 1'b0};
            nand_host_pkg::REG_ADDR:   s_nxt.rdata = {4'h0, s_r.addr};
            nand_host_pkg::REG_DATA:   s_nxt.rdata = {16'h0000, s_r.rword};
            nand_host_pkg::REG_STATUS:
               s_nxt.rdata = {27'h0000000, s_r.timeout, s_r.refused, rb_s,
                              s_r.done, !idle};
            default:                   s_nxt.rdata = 32'h0000_0000;
         endcase
      end

      if (reg_write) begin
         unique case (reg_addr)
            nand_host_pkg::REG_CTRL: begin
               s_nxt.guard = reg_wdata[nand_host_pkg::CTRL_GUARD];
               if (!idle) begin
                  s_nxt.refused = 1'b1;
               end else begin
                  s_nxt.op       = new_op;
                  s_nxt.bus16    = reg_wdata[nand_host_pkg::CTRL_BUS16];
                  s_nxt.skip     = reg_wdata[nand_host_pkg::CTRL_SKIP];
                  s_nxt.wait_rdy = reg_wdata[nand_host_pkg::CTRL_WAIT];
                  if (reg_wdata[nand_host_pkg::CTRL_START]) begin
                     if (allowed && guarded) begin
                        s_nxt.ph  = nand_host_pkg::PH_SETUP;
                        s_nxt.idx = 3'd0;
                        s_nxt.cnt = 11'(nand_host_pkg::SETUP_CYC);
                     end else begin
                        s_nxt.refused = 1'b1;
                     end
                  end
               end
            end
            nand_host_pkg::REG_ADDR: begin
               if (idle) s_nxt.addr = reg_wdata[27:0];
               else s_nxt.refused = 1'b1;
            end
            nand_host_pkg::REG_DATA: begin
               if (idle) s_nxt.wword = reg_wdata[15:0];
               else s_nxt.refused = 1'b1;
            end
            nand_host_pkg::REG_STATUS: begin
               if (reg_wdata[nand_host_pkg::ST_DONE]) s_nxt.done = 1'b0;
               if (reg_wdata[nand_host_pkg::ST_REFUSED]) s_nxt.refused = 1'b0;
               if (reg_wdata[nand_host_pkg::ST_TIMEOUT]) s_nxt.timeout = 1'b0;
            end
            default: ;
         endcase
      end

      unique case (s_r.ph)
         nand_host_pkg::PH_IDLE: begin
            // Deselected: device sits in standby, bus released
            s_nxt.pins.ce_n  = 1'b1;
            s_nxt.pins.cle   = 1'b0;
            s_nxt.pins.ale   = 1'b0;
            s_nxt.pins.we_n  = 1'b1;
            s_nxt.pins.re_n  = 1'b1;
            s_nxt.pins.io_oe = 1'b0;
         end
         nand_host_pkg::PH_SETUP: begin
            s_nxt.pins.ce_n   = 1'b0;
            s_nxt.pins.cle    = st.kind == nand_host_pkg::K_CMD;
            s_nxt.pins.ale    = st.kind == nand_host_pkg::K_ADDR;
            s_nxt.pins.io_out = st.data;
            s_nxt.pins.io_oe  = st.kind != nand_host_pkg::K_DOUT;
            if (s_r.cnt == 11'd0) begin
               s_nxt.ph = nand_host_pkg::PH_LOW;
               if (st.kind == nand_host_pkg::K_DOUT) begin
                  s_nxt.pins.re_n = 1'b0;
                  s_nxt.cnt = 11'(nand_host_pkg::RD_LOW_CYC - 1);
               end else begin
                  s_nxt.pins.we_n = 1'b0;
                  s_nxt.cnt = 11'(nand_host_pkg::STROBE_CYC - 1);
               end
            end else begin
               s_nxt.cnt = s_r.cnt - 11'd1;
            end
         end
         nand_host_pkg::PH_LOW: begin
            if (s_r.cnt == 11'd0) begin
               if (st.kind == nand_host_pkg::K_DOUT) begin
                  s_nxt.rword = s_r.bus16 ? io_s : {8'h00, io_s[7:0]};
               end
               s_nxt.pins.we_n = 1'b1;
               s_nxt.pins.re_n = 1'b1;
               s_nxt.ph  = nand_host_pkg::PH_HIGH;
               s_nxt.cnt = 11'(nand_host_pkg::HOLD_CYC - 1);
            end else begin
               s_nxt.cnt = s_r.cnt - 11'd1;
            end
         end
         nand_host_pkg::PH_HIGH: begin
            if (s_r.cnt != 11'd0) begin
               s_nxt.cnt = s_r.cnt - 11'd1;
            end else if (s_r.idx != last_step(s_r.op, s_r.skip)) begin
               s_nxt.idx = s_r.idx + 3'd1;
               s_nxt.ph  = nand_host_pkg::PH_SETUP;
               s_nxt.cnt = 11'(nand_host_pkg::SETUP_CYC);
            end else if (waits) begin
               // Select stays low through the load wait
               s_nxt.pins.cle   = 1'b0;
               s_nxt.pins.ale   = 1'b0;
               s_nxt.pins.io_oe = 1'b0;
               s_nxt.ph  = nand_host_pkg::PH_WAIT_BUSY;
               s_nxt.cnt = 11'(nand_host_pkg::WB_CYC - 1);
            end else begin
               s_nxt.ph   = nand_host_pkg::PH_IDLE;
               s_nxt.done = 1'b1;
            end
         end
         nand_host_pkg::PH_WAIT_BUSY: begin
            if (s_r.cnt == 11'd0) begin
               s_nxt.ph = nand_host_pkg::PH_WAIT_READY;
            end else begin
               s_nxt.cnt = s_r.cnt - 11'd1;
            end
         end
         nand_host_pkg::PH_WAIT_READY: begin
            s_nxt.cnt = s_r.cnt + 11'd1;
            if (rb_s) begin
               s_nxt.ph   = nand_host_pkg::PH_IDLE;
               s_nxt.done = 1'b1;
            end else if (s_r.op == nand_host_pkg::OP_PAGE_READ
                         && s_r.cnt == 11'(LOAD_CYC - 1)) begin
               s_nxt.ph      = nand_host_pkg::PH_IDLE;
               s_nxt.done    = 1'b1;
               s_nxt.timeout = 1'b1;
            end
         end
         default: s_nxt.ph = nand_host_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{ph: nand_host_pkg::PH_IDLE, op: nand_host_pkg::OP_PAGE_READ,
                  idx: 3'd0, cnt: 11'd0, bus16: 1'b0, skip: 1'b0,
                  guard: 1'b0, wait_rdy: 1'b0, addr: 28'h0000000,
                  wword: 16'h0000, rword: 16'h0000, done: 1'b0,
                  refused: 1'b0, timeout: 1'b0,
                  pins: nand_host_pkg::PINS_IDLE, rdata: 32'h0000_0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign pins      = s_r.pins;
endmodule
`default_nettype wire

// >>> testbench/nand_host_ctrl_sva.sv
// Assertions on the controller's flash pins
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl_sva (
   input wire logic                    clock,
   input wire logic                    arst_n,
   input wire nand_host_pkg::pin_out_t pins
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_cmd_levels: assert property (
      $rose(pins.we_n) && pins.cle |-> !pins.ale && !pins.ce_n && pins.re_n
   ) else $error("command latched with wrong levels");
   a_addr_levels: assert property (
      $rose(pins.we_n) && pins.ale |-> !pins.cle && !pins.ce_n && pins.re_n
   ) else $error("address latched with wrong levels");
   a_upper_quiet: assert property (
      $rose(pins.we_n) && (pins.cle || pins.ale) |-> pins.io_out[15:8] == 8'h00
   ) else $error("upper lines not low in command or address");
   a_we_width: assert property (
      $fell(pins.we_n) |=> !pins.we_n ##1 pins.we_n
   ) else $error("write strobe low time wrong");
   a_re_width: assert property (
      $fell(pins.re_n) |=> !pins.re_n [*4] ##1 pins.re_n
   ) else $error("read strobe low time wrong");
   a_read_levels: assert property (
      $fell(pins.re_n) |-> !pins.ce_n && pins.we_n && !pins.cle && !pins.ale
   ) else $error("read strobe with wrong levels");
   a_read_release: assert property (
      !pins.re_n |-> !pins.io_oe
   ) else $error("controller drives lines during read");
   a_write_drive: assert property (
      !pins.we_n |-> pins.io_oe && !pins.ce_n
   ) else $error("write strobe without driven lines");
   a_standby_idle: assert property (
      pins.ce_n |-> pins.we_n && pins.re_n && !pins.io_oe
   ) else $error("strobe or drive while deselected");
   a_guard_modify: assert property (
      $rose(pins.we_n) && pins.cle && pins.io_out[7:0] inside
      {8'h80, 8'h85, 8'h60, 8'h10, 8'hD0, 8'h15} |-> pins.wp_n
   ) else $error("modify command with guard low");
endmodule
bind nand_host_ctrl nand_host_ctrl_sva u_nand_host_ctrl_sva (
   .clock(clock), .arst_n(arst_n), .pins(pins));
`default_nettype wire

// >>> testbench/flash_model.sv
// Behavioural flash device facing the controller's pins
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
   parameter int LOAD_NS = 600
) (
   input  wire nand_host_pkg::pin_out_t pins,
   input  wire logic                    slow,
   output var  logic [15:0]             io_q,
   output var  logic                    busy_pull
);
   logic [7:0]  ab [4];
   logic [7:0]  row;
   logic [7:0]  last_cmd;
   logic [11:0] col;
   logic [15:0] last;
   logic [15:0] din;
   int          acnt;
   int          n_mod;
   int          n_read_cmd;
   // Powers up ready in read mode with lines released
   initial begin
      busy_pull = 1'b0;
      io_q = 16'hFFFF;
      last = 16'h0000;
      acnt = 0;
      n_mod = 0;
      n_read_cmd = 0;
   end
   // Load runs to its end whatever select does meanwhile
   task automatic load_page();
      busy_pull = 1'b1;
      #(slow ? 5 * LOAD_NS : LOAD_NS);
      busy_pull = 1'b0;
   endtask
   task automatic command(input logic [7:0] c);
      last_cmd = c;
      case (c)
         8'h00: n_read_cmd++;
         8'h30: if (acnt == 4) begin
            col = {ab[1][3:0], ab[0]};
            row = ab[2];
            fork
               load_page();
            join_none
         end
         8'hE0: col = {ab[1][3:0], ab[0]};
         8'h80, 8'h85, 8'h60: if (pins.wp_n) n_mod++;
         default: ;
      endcase
      acnt = 0;
   endtask
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.re_n) begin
         if (pins.cle && !pins.ale) begin
            // Only reset and status get through while busy
            if (!busy_pull || pins.io_out[7:0] inside {8'hFF, 8'h70})
               command(pins.io_out[7:0]);
         end else if (pins.ale && !pins.cle) begin
            ab[acnt[1:0]] = pins.io_out[7:0];
            acnt++;
         end else if (!pins.cle && !pins.ale && pins.wp_n) begin
            din = pins.io_out;
         end
      end
   end
   // Each read strobe fall puts out the column's word and steps on
   always @(negedge pins.re_n) begin
      if (!pins.ce_n && pins.we_n && !pins.cle && !pins.ale) begin
         last = {row, col[7:0] ^ 8'hA5};
         io_q = last;
         col++;
      end
   end
   // Released or deselected lines show the inverse of the last word
   always @(posedge pins.re_n or posedge pins.ce_n) io_q = ~last;
endmodule
`default_nettype wire

// >>> testbench/nand_host_ctrl_bench.sv
// Self-checking bench for the flash bus controller
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl_bench;
   logic                    clock;
   logic                    arst_n;
   logic [4:0]              reg_addr;
   logic [31:0]             reg_wdata;
   logic                    reg_write;
   logic                    reg_read;
   logic [31:0]             reg_rdata;
   logic [31:0]             v;
   logic [27:0]             a;
   logic [15:0]             io_q;
   logic                    slow;
   logic                    busy_pull;
   wire  logic              ready_busy_n;
   nand_host_pkg::pin_out_t pins;
   int                      mismatches;
   int                      checks_done;
   // Wired ready line with its pull-up
   assign ready_busy_n = busy_pull ? 1'b0 : 1'b1;
   nand_host_ctrl #(.LOAD_CYC(40)) u_nand_host_ctrl (
      .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .pins(pins), .ready_busy_n(ready_busy_n),
      .io_in(io_q));
   flash_model u_flash_model (.pins(pins), .slow(slow), .io_q(io_q),
      .busy_pull(busy_pull));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] ad, input logic [31:0] d);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [4:0] ad, output logic [31:0] d);
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clock);
   endtask
   task automatic rc(input logic [4:0] ad, input logic [31:0] exp,
         input string what, input logic [31:0] m = 32'hFFFFFFFF);
      rd(ad, v);
      chk(what, exp & m, v & m);
   endtask
   task automatic poll(input int b);
      int i;
      for (i = 0; i < 300; i++) begin
         rd(5'h0C, v);
         if (v[b] === 1'b1) break;
      end
      if (i == 300) begin
         mismatches++;
         $display("ERROR status bit %0d expected 1 seen 0", b);
         wrap_up();
      end
   endtask
   task automatic run(input logic [31:0] c, st, input string what);
      wr(5'h00, c);
      poll(1);
      chk(what, st, v & 32'h1B);
      wr(5'h0C, 32'h1A);
   endtask
   function automatic logic [31:0] mk(input logic [2:0] op,
         input logic b16, skip, guard);
      return {24'h0, 1'b0, guard, skip, b16, op, 1'b1};
   endfunction
   function automatic logic [31:0] mab();
      return {u_flash_model.ab[3], u_flash_model.ab[2],
              u_flash_model.ab[1], u_flash_model.ab[0]};
   endfunction
   initial begin
      arst_n = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      slow = 1'b0;
      mismatches = 0;
      checks_done = 0;
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rc(5'h0C, 32'h4, "status at reset");
      rc(5'h00, 32'h0, "ctrl at reset");
      rc(5'h10, 32'h0, "unmapped read");
      chk("guard pin at reset", 32'h0, {31'h0, pins.wp_n});
      $display("reset test done");
      a = 28'hABCD7F2;
      wr(5'h04, {4'h0, a});
      run(mk(3'h0, 1'b0, 1'b0, 1'b0), 32'h2, "page read x8");
      chk("x8 address", {a[27:12], 4'h0, a[11:0]}, mab());
      for (int i = 0; i < 2; i++) begin
         run(mk(3'h3, 1'b0, 1'b0, 1'b0), 32'h2, "read word x8");
         rc(5'h08, {24'h0, (a[7:0] + 8'(i)) ^ 8'hA5}, "x8 word", 32'hFF);
      end
      a = 28'h0A5C3A5;
      wr(5'h04, {4'h0, a});
      run(mk(3'h0, 1'b1, 1'b1, 1'b0), 32'h2, "page read x16");
      chk("x16 address", {a[26:11], 5'h0, a[10:0]}, mab());
      chk("leading read count", 32'h1, u_flash_model.n_read_cmd);
      run(mk(3'h3, 1'b1, 1'b0, 1'b0), 32'h2, "read word x16");
      rc(5'h08, {16'h0, a[18:11], 8'h00}, "x16 word");
      wr(5'h04, {4'h0, a[27:11], 11'h010});
      run(mk(3'h1, 1'b1, 1'b0, 1'b0), 32'h2, "random out");
      run(mk(3'h3, 1'b1, 1'b0, 1'b0), 32'h2, "read word random");
      rc(5'h08, {16'h0, a[18:11], 8'hB5}, "random word");
      $display("page read tests done");
      wr(5'h08, 32'h80);
      wr(5'h00, mk(3'h6, 1'b1, 1'b0, 1'b0));
      rc(5'h0C, 32'h08, "guarded cmd", 32'h1B);
      wr(5'h0C, 32'h1A);
      run(mk(3'h6, 1'b1, 1'b0, 1'b1), 32'h2, "raw cmd");
      chk("modify starts", 32'h1, u_flash_model.n_mod);
      wr(5'h08, 32'h1234);
      run(mk(3'h5, 1'b1, 1'b0, 1'b1), 32'h2, "write word");
      chk("written word", 32'h1234, {16'h0, u_flash_model.din});
      wr(5'h00, mk(3'h5, 1'b1, 1'b0, 1'b0));
      rc(5'h0C, 32'h08, "guarded write", 32'h1B);
      wr(5'h0C, 32'h1A);
      run(mk(3'h7, 1'b1, 1'b0, 1'b0), 32'h2, "raw addr");
      chk("raw addr byte", 32'h34, {24'h0, u_flash_model.ab[0]});
      $display("guard tests done");
      slow <= 1'b1;
      wr(5'h04, 32'h0012345);
      run(mk(3'h0, 1'b0, 1'b0, 1'b0), 32'h12, "slow load");
      wr(5'h08, 32'h90);
      wr(5'h00, mk(3'h6, 1'b0, 1'b0, 1'b0));
      rc(5'h0C, 32'h08, "cmd while busy", 32'h1B);
      wr(5'h0C, 32'h1A);
      run(mk(3'h2, 1'b0, 1'b0, 1'b0), 32'h2, "status while busy");
      chk("cmd while busy", 32'h70, {24'h0, u_flash_model.last_cmd});
      wr(5'h08, 32'h70);
      run(mk(3'h6, 1'b0, 1'b0, 1'b0), 32'h2, "raw status busy");
      run(mk(3'h4, 1'b0, 1'b0, 1'b0), 32'h2, "reset while busy");
      chk("reset cmd", 32'hFF, {24'h0, u_flash_model.last_cmd});
      poll(2);
      slow <= 1'b0;
      $display("busy tests done");
      wrap_up();
   end
endmodule
`default_nettype wire
